// ===== hw/cfsr_pkg.sv
package cfsr_pkg;
    // bus geometry
    localparam int DATA_W = 32; // axi data width
    localparam int ADDR_W = 12; // axi address width
    localparam int IDX_W = 10; // word index width
    localparam int REG_W = 8; // documented register width
    localparam int CH_W = 4; // channels per register
    localparam int N_KIND = 4; // fault registers in the bank

    // word indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OL_OFF = 10'h004; // off-state open load
    localparam logic [IDX_W-1:0] IDX_OL_ON = 10'h005; // on-state open load
    localparam logic [IDX_W-1:0] IDX_ILIM = 10'h006; // current limit
    localparam logic [IDX_W-1:0] IDX_TSD = 10'h007; // thermal shutdown
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h010; // event status, w1c
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h011; // event mask

    // fault kind positions in the flag array
    localparam int KIND_OL_OFF = 0; // off-state open load
    localparam int KIND_OL_ON = 1; // on-state open load
    localparam int KIND_ILIM = 2; // current limit
    localparam int KIND_TSD = 3; // thermal shutdown

    // reset values
    localparam logic [CH_W-1:0] FLAG_RST = 4'h0; // all fault flags clear
    localparam logic [N_KIND-1:0] IRQ_RST = 4'h0; // events clear, all masked

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0; // accepted
    localparam logic [1:0] RESP_DECERR = 2'h3; // no register there

    // live fault conditions from the analog side, one bit per channel
    typedef struct packed {
        logic [CH_W-1:0] tsd; // over shutdown temperature
        logic [CH_W-1:0] ilim; // limiting current now
        logic [CH_W-1:0] ol_on; // open load while on
        logic [CH_W-1:0] ol_off; // open load while off
    } cfsr_cond_s;
endpackage

// ===== hw/cfsr_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module cfsr_top #(
    parameter int NUM_CH = cfsr_pkg::CH_W // channels in use
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire cfsr_pkg::cfsr_cond_s fault_cond, // live fault levels
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [cfsr_pkg::ADDR_W-1:0] awaddr, // write address
    input wire logic [2:0] awprot, // unused protection
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    input wire logic [cfsr_pkg::DATA_W-1:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    output logic [1:0] bresp, // write response code
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    input wire logic [cfsr_pkg::ADDR_W-1:0] araddr, // read address
    input wire logic [2:0] arprot, // unused protection
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [cfsr_pkg::DATA_W-1:0] rdata, // read data
    output logic [1:0] rresp, // read response code
    output logic irq // level, unmasked event pending
);

    // word map, byte address four times the index
    // index 4: off-state open load flags
    // index 5: on-state open load flags
    // index 6: current limit flags
    // index 7: thermal shutdown flags
    // index 16: event status, write one to clear
    // index 17: event mask, one enables irq
    // fault registers are read-only, writes ignored
    // protection bits are not checked
    // only the low byte lane carries register bits
    // reserved upper bits always read zero
    // refuse channel counts the register layout cannot hold
    if (NUM_CH < 1 || NUM_CH > cfsr_pkg::CH_W) begin : g_bad_ch
        $error("cfsr_top: NUM_CH must be 1 to 4");
    end

    localparam int CH = cfsr_pkg::CH_W; // local shorthand
    localparam int NK = cfsr_pkg::N_KIND; // local shorthand
    localparam int IW = cfsr_pkg::IDX_W; // local shorthand

    // unused channels tied off at the source,
    // so flags, events and reads all see zero for them
    // channel enable, unused channels never set
    logic [CH-1:0] ch_en; // one per channel
    for (genvar c = 0; c < CH; c++) begin : g_chen
        assign ch_en[c] = (c < NUM_CH);
    end

    // index order follows the package kind positions,
    // the same order as the event status bits
    // conditions arranged by kind
    logic [NK-1:0][CH-1:0] cond_v; // live levels per kind
    assign cond_v[cfsr_pkg::KIND_OL_OFF] = fault_cond.ol_off & ch_en;
    assign cond_v[cfsr_pkg::KIND_OL_ON] = fault_cond.ol_on & ch_en;
    assign cond_v[cfsr_pkg::KIND_ILIM] = fault_cond.ilim & ch_en;
    assign cond_v[cfsr_pkg::KIND_TSD] = fault_cond.tsd & ch_en;

    // flag and event storage
    logic [NK-1:0][CH-1:0] flag_r; // sticky fault flags
    logic [NK-1:0] rd_clr; // clearing read of kind k this cycle
    logic [NK-1:0] ev_set; // a flag of kind k newly sets
    logic [NK-1:0] irq_stat_r; // event status, w1c
    logic [NK-1:0] irq_mask_r; // event mask, 1 enables

    // write channel state
    logic aw_hold_r; // address captured
    logic w_hold_r; // data captured
    logic [IW-1:0] aw_idx_r; // captured word index
    logic [cfsr_pkg::REG_W-1:0] wdata_r; // captured low byte
    logic wstrb0_r; // low byte lane enabled
    logic bvalid_r; // response pending
    logic [1:0] bresp_r; // response code
    logic wr_fire; // perform the write now
    logic wr_hit; // captured index is mapped

    // read channel state
    logic rvalid_r; // read data pending
    logic [cfsr_pkg::DATA_W-1:0] rdata_r; // read data
    logic [1:0] rresp_r; // read response code
    logic ar_fire; // read address taken
    logic [IW-1:0] ar_idx; // read word index
    logic [cfsr_pkg::REG_W-1:0] rd_byte; // selected register value
    logic rd_hit; // read index is mapped

    // answer timing, counted in clock edges:
    // read data registered at the same edge that takes the address
    // write response one edge after both halves held
    // no further wait states are ever inserted
    // trade-off: a read every second cycle at best
    // one read and one write may overlap freely
    // ready terms: one write and one read in flight at most
    assign awready = ~aw_hold_r & ~bvalid_r;
    assign wready = ~w_hold_r & ~bvalid_r;
    assign arready = ~rvalid_r;
    assign ar_fire = arvalid & arready;
    assign ar_idx = araddr[cfsr_pkg::ADDR_W-1:cfsr_pkg::ADDR_W-cfsr_pkg::IDX_W];
    assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;

    // clear strobe from the address handshake,
    // not from the data handshake: the reported value
    // is captured at the same edge, so no flag is lost
    // a stalled rready does not delay the clear
    // a read of a fault register is its clearing read
    always_comb begin
        rd_clr = '0;
        if (ar_fire) begin
            rd_clr[cfsr_pkg::KIND_OL_OFF] = (ar_idx == cfsr_pkg::IDX_OL_OFF);
            rd_clr[cfsr_pkg::KIND_OL_ON] = (ar_idx == cfsr_pkg::IDX_OL_ON);
            rd_clr[cfsr_pkg::KIND_ILIM] = (ar_idx == cfsr_pkg::IDX_ILIM);
            rd_clr[cfsr_pkg::KIND_TSD] = (ar_idx == cfsr_pkg::IDX_TSD);
        end
    end

    // flag update per edge:
    // no read: flag ors in the live condition
    // clearing read: flag takes the live condition
    // so a fault present at the read survives it
    // and a fault arriving with the read is never lost
    // limitation: no memory of a pending clear,
    // a later read is needed once the fault has gone
    // reset value all clear for every kind
    // one sticky flag bank per fault kind
    for (genvar k = 0; k < NK; k++) begin : g_kind
        // set while condition present, clear only on read with it gone
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                flag_r[k] <= cfsr_pkg::FLAG_RST;
            end else if (rd_clr[k]) begin
                // condition still present keeps the flag set
                flag_r[k] <= cond_v[k];
            end else begin
                flag_r[k] <= flag_r[k] | cond_v[k];
            end
        end
        // event when any channel goes from clear to set
        assign ev_set[k] = |(cond_v[k] & ~flag_r[k]);
    end

    // read mux works on the address as offered,
    // used only in the cycle of the handshake
    // unmapped indices answer with a decode error
    // register read mux, bits above the channels read zero
    always_comb begin
        rd_byte = '0;
        rd_hit = 1'b1;
        case (ar_idx)
            cfsr_pkg::IDX_OL_OFF: begin
                rd_byte[CH-1:0] = flag_r[cfsr_pkg::KIND_OL_OFF];
            end
            cfsr_pkg::IDX_OL_ON: begin
                rd_byte[CH-1:0] = flag_r[cfsr_pkg::KIND_OL_ON];
            end
            cfsr_pkg::IDX_ILIM: begin
                rd_byte[CH-1:0] = flag_r[cfsr_pkg::KIND_ILIM];
            end
            cfsr_pkg::IDX_TSD: begin
                rd_byte[CH-1:0] = flag_r[cfsr_pkg::KIND_TSD];
            end
            cfsr_pkg::IDX_IRQ_STAT: begin
                rd_byte[NK-1:0] = irq_stat_r;
            end
            cfsr_pkg::IDX_IRQ_MASK: begin
                rd_byte[NK-1:0] = irq_mask_r;
            end
            default: begin
                rd_hit = 1'b0; // unmapped
            end
        endcase
    end

    // read data captured before the clear lands, so the set value is seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= cfsr_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            // upper bits of the byte already zero from the mux
            rdata_r <= {{(cfsr_pkg::DATA_W - cfsr_pkg::REG_W){1'b0}}, rd_byte};
            rresp_r <= rd_hit ? cfsr_pkg::RESP_OKAY : cfsr_pkg::RESP_DECERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0; // answer taken
        end
    end

    // write halves may arrive in either order,
    // each held until the other has come
    // ready drops while a half is held or answered
    // write address capture, independent of data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_idx_r <= '0;
        end else if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            aw_idx_r <= awaddr[cfsr_pkg::ADDR_W-1:cfsr_pkg::ADDR_W-cfsr_pkg::IDX_W];
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    // write data capture, only the low byte carries bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
        end else if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= wdata[cfsr_pkg::REG_W-1:0];
            wstrb0_r <= wstrb[0];
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    // fault registers are read-only: writes there are accepted and dropped
    always_comb begin
        case (aw_idx_r)
            cfsr_pkg::IDX_OL_OFF, cfsr_pkg::IDX_OL_ON,
            cfsr_pkg::IDX_ILIM, cfsr_pkg::IDX_TSD,
            cfsr_pkg::IDX_IRQ_STAT, cfsr_pkg::IDX_IRQ_MASK: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // decode error for an unmapped index,
    // okay otherwise, even where nothing changes
    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= cfsr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? cfsr_pkg::RESP_OKAY : cfsr_pkg::RESP_DECERR;
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // interrupt path:
    // event = a flag going from clear to set
    // a flag held set raises no further event
    // mask resets to zero, so irq stays low after reset
    // event mask, plain read/write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= cfsr_pkg::IRQ_RST;
        end else if (wr_fire && wstrb0_r && aw_idx_r == cfsr_pkg::IDX_IRQ_MASK) begin
            irq_mask_r <= wdata_r[NK-1:0];
        end
    end

    // clear and new event in one edge:
    // the new event wins, so none is ever missed
    // event status: new sets win over a same-cycle write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= cfsr_pkg::IRQ_RST;
        end else if (wr_fire && wstrb0_r && aw_idx_r == cfsr_pkg::IDX_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~wdata_r[NK-1:0]) | ev_set;
        end else begin
            irq_stat_r <= irq_stat_r | ev_set;
        end
    end

    // response and data outputs straight from flip-flops
    // ready terms above are combinational by design
    // outputs; irq is a gate of two registers, so glitch free in practice
    assign irq = |(irq_stat_r & irq_mask_r);
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

endmodule

// ===== verification/cfsr_props.sv
`timescale 1ns/1ps
// fault flag relations seen at the read port
module cfsr_props #(
    parameter int NUM_CH = 4 // channels in use
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire cfsr_pkg::cfsr_cond_s fault_cond, // fault levels
    input wire logic arvalid, // read addr valid
    input wire logic arready, // read addr ready
    input wire logic [cfsr_pkg::ADDR_W-1:0] araddr, // read addr
    input wire logic rvalid, // read data valid
    input wire logic [cfsr_pkg::DATA_W-1:0] rdata, // read data
    input wire logic [1:0] rresp, // read resp
    input wire logic irq // interrupt
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // read taken here, not on the first edge out of reset
    sequence s_rd(logic [9:0] i);
        $past(aresetn) && arvalid && arready && araddr[11:2] == i;
    endsequence
    // faults seen before the read must show in it
    property p_set(logic [9:0] i, logic [3:0] c);
        s_rd(i) |=> (rdata[3:0] & $past(c, 2)) == $past(c, 2);
    endproperty
    // two reads with the fault gone leave nothing
    property p_clr(logic [9:0] i, logic [3:0] c);
        s_rd(i) ##0 (c == 4'h0) ##1 (c == 4'h0) ##1 s_rd(i) |=> rdata[3:0] == 4'h0;
    endproperty
    // fault present at a read survives it
    property p_hold(logic [9:0] i, logic [3:0] c);
        s_rd(i) ##0 (c != 4'h0) ##2 s_rd(i) |=> (rdata[3:0] & $past(c, 3)) == $past(c, 3);
    endproperty
    a_offol_sets: assert property (p_set(10'h004, fault_cond.ol_off))
        else $error("off-state open load flag missing");
    a_onol_sets: assert property (p_set(10'h005, fault_cond.ol_on))
        else $error("on-state open load flag missing");
    a_ilim_sets: assert property (p_set(10'h006, fault_cond.ilim))
        else $error("current limit flag missing");
    a_tsd_sets: assert property (p_set(10'h007, fault_cond.tsd))
        else $error("thermal flag missing");
    a_onol_clears: assert property (p_clr(10'h005, fault_cond.ol_on))
        else $error("on-state open load flag not cleared");
    a_ilim_clears: assert property (p_clr(10'h006, fault_cond.ilim))
        else $error("current limit flag not cleared");
    a_tsd_holds: assert property (p_hold(10'h007, fault_cond.tsd))
        else $error("thermal flag cleared while hot");
    a_resv_zero: assert property (rvalid |-> rdata[31:4] == 28'h0)
        else $error("upper read bits not zero");
    c_tsd_read: cover property (s_rd(10'h007));
    c_decerr: cover property (rvalid && rresp == 2'h3);
    c_irq: cover property (irq);
endmodule

bind cfsr_top cfsr_props #(.NUM_CH(NUM_CH)) i_cfsr_props (.aclk(aclk), .aresetn(aresetn),
    .fault_cond(fault_cond), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .irq(irq));

// ===== verification/cfsr_host.sv
`timescale 1ns/1ps
// bus master standing in for the host controller
module cfsr_host (
    input wire logic aclk, // clock
    output logic awvalid, // write addr valid
    input wire logic awready, // write addr ready
    output logic [11:0] awaddr, // write addr
    output logic wvalid, // write data valid
    input wire logic wready, // write data ready
    output logic [31:0] wdata, // write data
    input wire logic bvalid, // write resp valid
    output logic bready, // write resp ready
    input wire logic [1:0] bresp, // write resp
    output logic arvalid, // read addr valid
    input wire logic arready, // read addr ready
    output logic [11:0] araddr, // read addr
    input wire logic rvalid, // read data valid
    output logic rready, // read data ready
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp // read resp
);
    // idle, responses always taken at once
    initial begin
        {awvalid, wvalid, arvalid, bready, rready} <= 5'h03;
        {awaddr, araddr, wdata} <= 56'h0;
    end
    // one read; address scrambled once released
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    // one write; each half released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        do begin
            @(posedge aclk);
            ad |= awready;
            wd |= wready;
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end while (!(ad && wd));
        awaddr <= ~a;
        wdata <= ~d;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask
endmodule

// ===== verification/cfsr_top_tb.sv
`timescale 1ns/1ps
module cfsr_top_tb;
    logic aclk = 1'b0; // clock
    logic aresetn = 1'b0; // reset, active low
    cfsr_pkg::cfsr_cond_s fault_cond = 16'h0000; // fault levels
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [11:0] awaddr, araddr; // addresses
    logic [31:0] wdata, rdata, d; // data
    logic [1:0] bresp, rresp, r; // responses
    int error_cnt = 0; // mismatches
    int checked = 0; // comparisons
    always #5 aclk = ~aclk;
    // protection ignored, full strobes
    cfsr_top i_cfsr_top (.aclk(aclk), .aresetn(aresetn), .fault_cond(fault_cond),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
    cfsr_host i_cfsr_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        i_cfsr_host.rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    task wc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
        i_cfsr_host.wr(a, v, r);
        chk("bresp", 32'(er), 32'(r));
    endtask
    // one-cycle fault, then one more edge for irq to settle
    task pulse(input logic [15:0] v);
        fault_cond <= v;
        @(posedge aclk);
        fault_cond <= 16'h0;
        @(posedge aclk);
    endtask
    task t_reset;
        for (int k = 0; k < 4; k++)
            rc(12'h010 + 12'(4 * k), 32'h0);
        chk("irq", 32'h0, 32'(irq));
        $display("reset test done");
    endtask
    // held fault, read twice, drop it, read twice
    task t_faults;
        logic [11:0] a;
        logic [31:0] p;
        for (int k = 0; k < 4; k++) begin
            a = 12'h010 + 12'(4 * k);
            p = 32'(k + 9);
            fault_cond <= 16'(p << (4 * k));
            @(posedge aclk);
            rc(a, p);
            rc(a, p);
            fault_cond <= 16'h0;
            @(posedge aclk);
            rc(a, p);
            rc(a, 32'h0);
        end
        $display("fault flag test done");
    endtask
    task t_irq;
        rc(12'h040, 32'hF);
        wc(12'h040, 32'hF);
        rc(12'h040, 32'h0);
        wc(12'h044, 32'h8);
        rc(12'h044, 32'h8);
        pulse(16'h0100);
        chk("irq", 32'h0, 32'(irq));
        pulse(16'h1000);
        chk("irq", 32'h1, 32'(irq));
        rc(12'h040, 32'hC);
        wc(12'h040, 32'h8);
        chk("irq", 32'h0, 32'(irq));
        $display("interrupt test done");
    endtask
    // unmapped place, and a write to a fault register
    task t_bad;
        rc(12'h100, 32'h0, cfsr_pkg::RESP_DECERR);
        wc(12'h100, 32'hFFFFFFFF, cfsr_pkg::RESP_DECERR);
        wc(12'h018, 32'hFFFFFFFF);
        rc(12'h018, 32'h1);
        rc(12'h018, 32'h0);
        $display("bad access test done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_faults;
        t_irq;
        t_bad;
        print_verdict;
    end
endmodule
